// ### pkg/psp_pkg.sv
// psp_pkg: constants, types and helper functions of the power-management serial slave port
// What this block does
// - the port answers only to the 7-bit slave address 1001000 and ignores traffic for any other address.
// - the port works for standard and fast mode transfers with serial clock rates up to 400 kHz.
// - a read of a register address outside the defined map returns 00h.
// - data bits change only while the serial clock is low; a change while it is high is only a start or stop.
// - each data bit is carried by exactly one serial clock pulse.
// - once addressed, the port acknowledges every received byte by holding the data line low through the ninth high phase.
// - after a withheld acknowledge on a read byte the port releases the data line so the master can stop.
// - all registers are held at their defaults while undervoltage lockout is active.
// - optionally all registers return to defaults when the pushbutton input stays low for longer than 15 s.
`default_nettype none
package psp_pkg;
    // ----------------------------------------
    // bus identity and timing
    // ----------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam int unsigned SCL_MAX_KHZ = 400;
    localparam int unsigned CLK_SYS_KHZ = 40000;
    // oversampling ratio of the system clock against the fastest bus clock
    localparam int unsigned SCL_OVERSAMPLE = CLK_SYS_KHZ / SCL_MAX_KHZ;
    localparam int unsigned PB_HOLD_S = 15;
    localparam int unsigned PB_HOLD_CYCLES = PB_HOLD_S * CLK_SYS_KHZ * 1000;
    localparam int unsigned PB_CNT_W = 30;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int unsigned REG_COUNT = 32;
    localparam int unsigned REG_AW = 5;
    localparam logic [7:0] REG_FIRST = 8'h01;
    localparam logic [7:0] REG_LAST = 8'h1F;
    localparam logic [7:0] PPATH_ADDR = 8'h01;
    localparam logic [7:0] PPATH_DEFAULT = 8'h0D;
    localparam logic [3:0] PIN_IDLE = 4'hB;
    // ----------------------------------------
    // protocol states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PSP_IDLE = 3'b000,
        PSP_RX = 3'b001,
        PSP_ACK = 3'b010,
        PSP_TX = 3'b011,
        PSP_MACK = 3'b100,
        PSP_TXLD = 3'b101
    } psp_state_t;

    // address decode shared by the write and read paths
    function automatic logic in_map(input logic [7:0] addr);
        in_map = (addr >= REG_FIRST) && (addr <= REG_LAST);
    endfunction : in_map

    // value every register takes on reset and on a defaults load
    function automatic logic [7:0] reg_default(input logic [7:0] addr);
        reg_default = (addr == PPATH_ADDR) ? PPATH_DEFAULT : 8'h00;
    endfunction : reg_default
endpackage : psp_pkg
`default_nettype wire

// ### rtl/psp_reg_mem.sv
// psp_reg_mem: register storage with registered read data and a defaults load
`timescale 1ns/100ps
`default_nettype none
module psp_reg_mem (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] word_reg [psp_pkg::REG_COUNT];

    // ----------------------------------------
    // storage words
    // ----------------------------------------
    for (genvar i = 0; i < psp_pkg::REG_COUNT; i++) begin : g_word
        // clear outranks a write so a lockout during a transfer leaves defaults behind
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                word_reg[i] <= psp_pkg::reg_default(8'(i));
            end else if (clear) begin
                word_reg[i] <= psp_pkg::reg_default(8'(i));
            end else if (wr_en && psp_pkg::in_map(wr_addr) && wr_addr == 8'(i)) begin
                word_reg[i] <= wr_data;
            end
        end
    end

    // read port: unmapped addresses read as zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (psp_pkg::in_map(rd_addr)) begin
            rd_data <= word_reg[rd_addr[psp_pkg::REG_AW-1:0]];
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_unlisted_zero;
        @(posedge clk_sys) disable iff (!rstn)
        !psp_pkg::in_map(rd_addr) |=> (rd_data == 8'h00);
    endproperty
    a_unlisted_zero: assert property (p_unlisted_zero) else $error("unmapped read not zero");

    property p_clear_default;
        @(posedge clk_sys) disable iff (!rstn)
        clear |=> (word_reg[1] == psp_pkg::PPATH_DEFAULT) && (word_reg[2] == 8'h00);
    endproperty
    a_clear_default: assert property (p_clear_default) else $error("defaults not loaded");
endmodule : psp_reg_mem
`default_nettype wire

// ### rtl/psp_slave_port.sv
// psp_slave_port: two-wire serial slave port with register file of the power-management device
`timescale 1ns/100ps
`default_nettype none
module psp_slave_port #(
    parameter int unsigned PB_HOLD_CYCLES = psp_pkg::PB_HOLD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_clock_link,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic undervoltage_lockout,
    input wire logic pushbutton_input_n,
    input wire logic pb_reset_enable,
    output logic reg_wr_pulse,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic regs_defaults
);
    localparam logic [psp_pkg::PB_CNT_W-1:0] PB_CMP = psp_pkg::PB_CNT_W'(PB_HOLD_CYCLES);

    // ----------------------------------------
    // link domain: sampling on the bus clock
    // ----------------------------------------
    logic [7:0] link_shift_reg;
    logic link_tgl_reg;

    // sampling on the true rising edge keeps the 100 ns setup margin at 400 kHz
    always_ff @(posedge serial_clock_link or negedge rstn) begin
        if (!rstn) begin
            link_shift_reg <= 8'h00;
        end else begin
            link_shift_reg <= {link_shift_reg[6:0], serial_data_line_in};
        end
    end

    // one toggle per clock pulse tells the system side that a new bit is held
    always_ff @(posedge serial_clock_link or negedge rstn) begin
        if (!rstn) begin
            link_tgl_reg <= 1'b0;
        end else begin
            link_tgl_reg <= ~link_tgl_reg;
        end
    end

    // ----------------------------------------
    // system domain: pin synchronisers
    // ----------------------------------------
    logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_st_reg, pin_prev_reg;
    logic [3:0] pin_raw;
    logic [2:0] tgl_sync_reg;
    logic scl_st, sda_st, undervoltage_lockout_st, pb_st;
    logic rise_evt, fall_evt, start_evt, stop_evt, bus_ok;

    assign pin_raw = {pushbutton_input_n, undervoltage_lockout, serial_data_line_in, serial_clock_link};
    assign scl_st = pin_st_reg[0];
    assign sda_st = pin_st_reg[1];
    assign undervoltage_lockout_st = pin_st_reg[2];
    assign pb_st = pin_st_reg[3];

    // three stages; a level counts only once the second and third agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_s1_reg <= psp_pkg::PIN_IDLE;
            pin_s2_reg <= psp_pkg::PIN_IDLE;
            pin_s3_reg <= psp_pkg::PIN_IDLE;
            pin_st_reg <= psp_pkg::PIN_IDLE;
            pin_prev_reg <= psp_pkg::PIN_IDLE;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_st_reg <= (pin_st_reg & (pin_s2_reg ^ pin_s3_reg)) | (pin_s3_reg & ~(pin_s2_reg ^ pin_s3_reg));
            pin_prev_reg <= pin_st_reg;
        end
    end

    // bit-ready toggle crossing; the held byte is stable for a whole bit time after it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tgl_sync_reg <= 3'h0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl_reg};
        end
    end

    // the option strap is a pin as well, so it gets the same three-stage filter
    logic [2:0] pben_sync_reg;
    logic pben_st_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pben_sync_reg <= 3'h0;
            pben_st_reg <= 1'b0;
        end else begin
            pben_sync_reg <= {pben_sync_reg[1:0], pb_reset_enable};
            if (pben_sync_reg[1] == pben_sync_reg[2]) begin
                pben_st_reg <= pben_sync_reg[2];
            end
        end
    end

    assign rise_evt = tgl_sync_reg[1] ^ tgl_sync_reg[2];
    assign fall_evt = pin_prev_reg[0] & ~scl_st;
    // data moving while the clock is high marks only start or stop
    assign start_evt = scl_st & pin_prev_reg[0] & pin_prev_reg[1] & ~sda_st;
    assign stop_evt = scl_st & pin_prev_reg[0] & ~pin_prev_reg[1] & sda_st;
    assign bus_ok = !undervoltage_lockout_st && !start_evt && !stop_evt;

    // ----------------------------------------
    // protocol state
    // ----------------------------------------
    psp_pkg::psp_state_t state_reg;
    logic [3:0] bitcnt_reg;
    logic [1:0] byte_idx_reg;
    logic read_dir_reg;
    logic [7:0] reg_ptr_reg, tx_byte_reg, rd_data;
    logic byte_done, addr_hit, load_tx;

    assign byte_done = bus_ok && rise_evt && state_reg == psp_pkg::PSP_RX && bitcnt_reg == 4'd7;
    assign addr_hit = link_shift_reg[7:1] == psp_pkg::SLAVE_ADDR;
    // first data bit of a read byte goes out on the fall that ends the previous ack
    assign load_tx = bus_ok && fall_evt && ((state_reg == psp_pkg::PSP_ACK && bitcnt_reg == 4'd1 && read_dir_reg
                     && byte_idx_reg == 2'd0) || state_reg == psp_pkg::PSP_TXLD);

    // lockout parks the port; a start always restarts address reception
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= psp_pkg::PSP_IDLE;
            bitcnt_reg <= 4'd0;
            byte_idx_reg <= 2'd0;
            read_dir_reg <= 1'b0;
        end else if (undervoltage_lockout_st) begin
            state_reg <= psp_pkg::PSP_IDLE;
        end else if (start_evt) begin
            state_reg <= psp_pkg::PSP_RX;
            bitcnt_reg <= 4'd0;
            byte_idx_reg <= 2'd0;
        end else if (stop_evt) begin
            state_reg <= psp_pkg::PSP_IDLE;
        end else begin
            case (state_reg)
                psp_pkg::PSP_RX: begin
                    if (byte_done && byte_idx_reg == 2'd0 && !addr_hit) begin
                        state_reg <= psp_pkg::PSP_IDLE;
                    end else if (byte_done) begin
                        state_reg <= psp_pkg::PSP_ACK;
                        bitcnt_reg <= 4'd0;
                        if (byte_idx_reg == 2'd0) begin
                            read_dir_reg <= link_shift_reg[0];
                        end
                    end else if (rise_evt) begin
                        bitcnt_reg <= bitcnt_reg + 4'd1;
                    end
                end
                psp_pkg::PSP_ACK: begin
                    if (fall_evt && bitcnt_reg == 4'd0) begin
                        bitcnt_reg <= 4'd1;
                    end else if (load_tx) begin
                        state_reg <= psp_pkg::PSP_TX;
                        bitcnt_reg <= 4'd0;
                    end else if (fall_evt) begin
                        state_reg <= psp_pkg::PSP_RX;
                        bitcnt_reg <= 4'd0;
                        byte_idx_reg <= (byte_idx_reg == 2'd2) ? 2'd2 : byte_idx_reg + 2'd1;
                    end
                end
                psp_pkg::PSP_TX: begin
                    if (rise_evt) begin
                        bitcnt_reg <= bitcnt_reg + 4'd1;
                    end else if (fall_evt && bitcnt_reg == 4'd8) begin
                        state_reg <= psp_pkg::PSP_MACK;
                    end
                end
                psp_pkg::PSP_MACK: begin
                    if (rise_evt && link_shift_reg[0]) begin
                        state_reg <= psp_pkg::PSP_IDLE;
                    end else if (rise_evt) begin
                        state_reg <= psp_pkg::PSP_TXLD;
                    end
                end
                psp_pkg::PSP_TXLD: begin
                    if (load_tx) begin
                        state_reg <= psp_pkg::PSP_TX;
                        bitcnt_reg <= 4'd0;
                    end
                end
                default: begin
                    state_reg <= psp_pkg::PSP_IDLE;
                end
            endcase
        end
    end

    // register pointer: set by the second byte, advanced after each written byte and each read byte the master acknowledges
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_ptr_reg <= 8'h00;
        end else if (byte_done && byte_idx_reg == 2'd1) begin
            reg_ptr_reg <= link_shift_reg;
        end else if (byte_done && byte_idx_reg == 2'd2) begin
            reg_ptr_reg <= reg_ptr_reg + 8'h01;
        end else if (bus_ok && rise_evt && state_reg == psp_pkg::PSP_MACK && !link_shift_reg[0]) begin
            reg_ptr_reg <= reg_ptr_reg + 8'h01;
        end
    end

    // transmit shifter: loaded from the read port, shifted on every fall while in PSP_TX
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_byte_reg <= 8'h00;
        end else if (load_tx) begin
            tx_byte_reg <= rd_data;
        end else if (fall_evt && state_reg == psp_pkg::PSP_TX) begin
            tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // data line drive (open drain, low only)
    // ----------------------------------------
    // every change except the release forced by lockout, start or stop happens on a clock fall, so the line is still while the clock is high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_data_line_oe <= 1'b0;
        end else if (!bus_ok) begin
            serial_data_line_oe <= 1'b0;
        end else if (load_tx) begin
            serial_data_line_oe <= ~rd_data[7];
        end else if (fall_evt && state_reg == psp_pkg::PSP_ACK && bitcnt_reg == 4'd0) begin
            serial_data_line_oe <= 1'b1;
        end else if (fall_evt && state_reg == psp_pkg::PSP_TX && bitcnt_reg != 4'd8) begin
            serial_data_line_oe <= ~tx_byte_reg[6];
        end else if (fall_evt) begin
            serial_data_line_oe <= 1'b0;
        end
    end

    // the pin level driven is always low; only the enable moves
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_data_line_out <= 1'b0;
        end else begin
            serial_data_line_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // register writes and defaults
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_wr_pulse <= 1'b0;
            reg_wr_addr <= 8'h00;
            reg_wr_data <= 8'h00;
        end else begin
            reg_wr_pulse <= byte_done && byte_idx_reg == 2'd2;
            if (byte_done && byte_idx_reg == 2'd2) begin
                reg_wr_addr <= reg_ptr_reg;
                reg_wr_data <= link_shift_reg;
            end
        end
    end

    // held-button timer; fires once, one cycle past the hold time
    logic [psp_pkg::PB_CNT_W-1:0] pb_cnt_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pb_cnt_reg <= '0;
        end else if (!pben_st_reg || pb_st) begin
            pb_cnt_reg <= '0;
        end else if (pb_cnt_reg <= PB_CMP) begin
            pb_cnt_reg <= pb_cnt_reg + 1'b1;
        end
    end

    // defaults stay forced for as long as lockout lasts
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regs_defaults <= 1'b0;
        end else begin
            regs_defaults <= undervoltage_lockout_st || (pben_st_reg && !pb_st && pb_cnt_reg == PB_CMP);
        end
    end

    psp_reg_mem u_mem (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clear(regs_defaults),
        .wr_en(reg_wr_pulse),
        .wr_addr(reg_wr_addr),
        .wr_data(reg_wr_data),
        .rd_addr(reg_ptr_reg),
        .rd_data(rd_data)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_addr_miss;
        @(posedge clk_sys) disable iff (!rstn)
        (byte_done && byte_idx_reg == 2'd0 && !addr_hit) |=> (state_reg == psp_pkg::PSP_IDLE) && !serial_data_line_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address not ignored");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (state_reg == psp_pkg::PSP_IDLE && $past(state_reg) == psp_pkg::PSP_IDLE) |-> !serial_data_line_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("data line driven while idle");

    property p_change_low;
        @(posedge clk_sys) disable iff (!rstn)
        ($changed(serial_data_line_oe) && !undervoltage_lockout_st) |-> !scl_st;
    endproperty
    a_change_low: assert property (p_change_low) else $error("data moved with clock high");

    property p_bit_count;
        @(posedge clk_sys) disable iff (!rstn)
        (bus_ok && rise_evt && state_reg == psp_pkg::PSP_RX && bitcnt_reg != 4'd7)
            |=> bitcnt_reg == $past(bitcnt_reg) + 4'd1;
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit count not one per pulse");

    property p_ack_hold;
        @(posedge clk_sys) disable iff (!rstn)
        (state_reg == psp_pkg::PSP_ACK && bitcnt_reg == 4'd1 && scl_st) |-> serial_data_line_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack not held low");

    property p_nack_release;
        @(posedge clk_sys) disable iff (!rstn)
        (bus_ok && rise_evt && state_reg == psp_pkg::PSP_MACK && link_shift_reg[0])
            |=> (state_reg == psp_pkg::PSP_IDLE) ##1 !serial_data_line_oe;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("line not released after nack");

    property p_undervoltage_lockout_idle;
        @(posedge clk_sys) disable iff (!rstn)
        undervoltage_lockout_st |=> (state_reg == psp_pkg::PSP_IDLE) && !serial_data_line_oe && regs_defaults;
    endproperty
    a_undervoltage_lockout_idle: assert property (p_undervoltage_lockout_idle) else $error("lockout did not force defaults");

    property p_pb_fire;
        @(posedge clk_sys) disable iff (!rstn)
        (pben_st_reg && !pb_st && pb_cnt_reg == PB_CMP) |=> regs_defaults ##1 (regs_defaults == $past(undervoltage_lockout_st));
    endproperty
    a_pb_fire: assert property (p_pb_fire) else $error("held button did not load defaults once");

    property p_write_pulse;
        @(posedge clk_sys) disable iff (!rstn)
        (byte_done && byte_idx_reg == 2'd2)
            |=> reg_wr_pulse && reg_wr_addr == $past(reg_ptr_reg) && reg_wr_data == $past(link_shift_reg);
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("data byte not written");
endmodule : psp_slave_port
`default_nettype wire

// ### test/psp_host_model.sv
// psp_host_model: behavioural bus master that drives the serial clock and pulls the data line
`timescale 1ns/100ps
`default_nettype none
module psp_host_model (
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    // ----------------------------------------
    // bus phases, all timed on falling system edges
    // ----------------------------------------
    initial begin
        scl = 1'b1; // clock stands still high outside frames
        sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    // start or repeated start; data falls while the clock is high
    task automatic start;
        sda_oe = 1'b0;
        wt(10);
        scl = 1'b1;
        wt(28);
        sda_oe = 1'b1;
        wt(28);
        scl = 1'b0;
    endtask : start
    task automatic stop;
        sda_oe = 1'b1;
        wt(10);
        scl = 1'b1;
        wt(28);
        sda_oe = 1'b0;
        wt(52);
    endtask : stop
    // 2.5 us per bit keeps the bus at 400 kHz; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_oe = ~b;
        wt(50);
        scl = 1'b1;
        wt(20);
        r = sda;
        wt(20);
        scl = 1'b0;
        wt(10);
    endtask : bit_x
    // msb first, then a ninth pulse for the acknowledge; m_ack_n high withholds it
    task automatic byte_x(input logic [7:0] d, input logic m_ack_n, output logic [7:0] r, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(m_ack_n, ack_n);
    endtask : byte_x
endmodule : psp_host_model
`default_nettype wire

// ### test/tb_pmic_i2c_slave_port.sv
// tb_pmic_i2c_slave_port: self-checking bench for the serial slave port driven by a host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_pmic_i2c_slave_port;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic lockout = 1'b0;
    logic button_n = 1'b1;
    logic pb_en = 1'b0;
    int def_cnt = 0;
    logic scl, host_oe, dut_out, dut_oe, wr_pulse, defaults, ack_n;
    logic [7:0] wr_addr, wr_data, rd_byte;
    logic [31:0] rnd = 32'h55CD9BCB;
    logic [16:0] exp_q[$];
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    event got_rd;
    // open-drain wire with pull-up: low whenever either party pulls it
    wire sda = ~(host_oe | dut_oe);
    always #12.5 clk_sys = ~clk_sys;
    psp_slave_port #(.PB_HOLD_CYCLES(50)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .serial_clock_link(scl),
        .serial_data_line_in(sda), .serial_data_line_out(dut_out), .serial_data_line_oe(dut_oe),
        .undervoltage_lockout(lockout), .pushbutton_input_n(button_n), .pb_reset_enable(pb_en),
        .reg_wr_pulse(wr_pulse), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .regs_defaults(defaults));
    psp_host_model u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(host_oe));
    // ----------------------------------------
    // watcher: every result is matched against the oldest note
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (wr_pulse === 1'b1) compare({1'b0, wr_addr, wr_data});
        if (defaults === 1'b1) def_cnt <= def_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            summarize();
        end
    end
    always @(got_rd) compare({1'b1, 8'h00, rd_byte});
    task automatic compare(input logic [16:0] got);
        logic [16:0] want;
        if (exp_q.size() == 0) begin
            error_cnt++;
            $display("ERROR result expected none seen %h", got);
        end else begin
            // pop once: the macro names its expected value twice
            want = exp_q.pop_front();
            `CHK("result", want, got)
        end
    endtask : compare
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // write one byte; a refused frame leaves no note, so any write pulse then is an error
    task automatic xfer(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, input logic nak);
        logic [7:0] r;
        if (!nak) exp_q.push_back({1'b0, a, d});
        u_host.start();
        u_host.byte_x(dev, 1'b1, r, ack_n);
        `CHK("addr_ack", nak, ack_n)
        u_host.byte_x(a, 1'b1, r, ack_n);
        `CHK("reg_ack", nak, ack_n)
        u_host.byte_x(d, 1'b1, r, ack_n);
        `CHK("data_ack", nak, ack_n)
        u_host.stop();
    endtask : xfer
    // read n bytes after a repeated start, the last one left unacknowledged
    task automatic rd(input logic [7:0] a, input int n, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] r;
        u_host.start();
        u_host.byte_x(8'h90, 1'b1, r, ack_n);
        `CHK("addr_ack", 1'b0, ack_n)
        u_host.byte_x(a, 1'b1, r, ack_n);
        u_host.start();
        u_host.byte_x(8'h91, 1'b1, r, ack_n);
        `CHK("read_ack", 1'b0, ack_n)
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({1'b1, 8'h00, (i != 0) ? e1 : e0});
            u_host.byte_x(8'hFF, i == n - 1, rd_byte, ack_n);
            -> got_rd;
        end
        u_host.wt(20);
        `CHK("release", 1'b1, sda)
        `CHK("drive_level", 1'b0, dut_out)
        u_host.stop();
    endtask : rd
    task automatic summarize;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [6:0] bad;
        int pb0;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        // write then read across the auto-increment, the default and an unmapped address
        rnd = lfsr(rnd);
        xfer(8'h90, 8'h03, rnd[7:0], 1'b0);
        rd(8'h03, 2, rnd[7:0], 8'h00);
        rd(8'h01, 1, 8'h0D, 8'h00);
        rd(8'h20, 1, 8'h00, 8'h00);
        $display("test write_read done");
        // a foreign address must leave the register untouched
        rnd = lfsr(rnd);
        bad = (rnd[6:0] == 7'h48) ? 7'h49 : rnd[6:0];
        xfer({bad, 1'b0}, 8'h05, rnd[15:8] | 8'h01, 1'b1);
        rd(8'h05, 1, 8'h00, 8'h00);
        $display("test foreign_address done");
        // lockout forces defaults and the port ignores the bus meanwhile
        rnd = lfsr(rnd);
        xfer(8'h90, 8'h01, {1'b1, rnd[6:0]}, 1'b0);
        lockout = 1'b1;
        repeat (10) @(negedge clk_sys);
        `CHK("defaults", 1'b1, defaults)
        xfer(8'h90, 8'h01, rnd[15:8], 1'b1);
        lockout = 1'b0;
        repeat (10) @(negedge clk_sys);
        rd(8'h01, 1, 8'h0D, 8'h00);
        $display("test lockout done");
        // held button reloads defaults only after the hold count
        rnd = lfsr(rnd);
        xfer(8'h90, 8'h02, rnd[7:0] | 8'h01, 1'b0);
        pb_en = 1'b1;
        pb0 = def_cnt;
        button_n = 1'b0;
        repeat (40) @(negedge clk_sys);
        `CHK("pb_early", pb0, def_cnt)
        repeat (30) @(negedge clk_sys);
        `CHK("pb_load", pb0 + 1, def_cnt)
        button_n = 1'b1;
        rd(8'h02, 1, 8'h00, 8'h00);
        $display("test button done");
        summarize();
    end
endmodule : tb_pmic_i2c_slave_port
`default_nettype wire
